// >>> hw/ijcr_reset_pulse.sv
/*
 * ijcr_reset_pulse: stretches a one-cycle trigger into a fixed-length
 * active-high reset for the internal blocks.
 * assumes: trigger is synchronous to clk_sys_in.
 */
`timescale 1ns/1ps
module ijcr_reset_pulse #(
    parameter int CYCLES = ijcr_pkg::SOFT_RESET_CYCLES
)
(
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rstn_in,
    // trigger and stretched reset
    input  wire logic trigger_in,
    output logic      reset_out
);
    logic [ijcr_pkg::SOFT_RESET_CNT_W-1:0] count_q;

    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
            count_q <= '0;
        else if (trigger_in)
            count_q <= ijcr_pkg::SOFT_RESET_CNT_W'(CYCLES);
        else if (count_q != '0)
            count_q <= count_q - 1'b1;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
            reset_out <= 1'b0;
        else
            reset_out <= trigger_in || (count_q != '0);
    end
endmodule

// >>> hw/ijcr_top.sv
/*
 * ijcr_top: isa jumperless setting register, io base update register
 * and the eight soft reset ports of the lan controller.
 * assumes: isa strobes are one-cycle pulses synchronous to clk_sys_in;
 * power-on values of the irq and io window selections are presented
 * on cfg inputs and captured after reset release when jumperless_in is set.
 */
`timescale 1ns/1ps
module ijcr_top
(
    // clock and reset
    input  wire logic                           clk_sys_in,
    input  wire logic                           rstn_in,
    // mode straps
    input  wire logic [1:0]                     mode_in,
    input  wire logic                           jumperless_in,
    input  wire logic [1:0]                     irq_cfg_in,
    input  wire logic [2:0]                     io_cfg_in,
    // isa register access
    input  wire logic [ijcr_pkg::ADDR_W-1:0]    sa_in,
    input  wire logic                           io_rd_in,
    input  wire logic                           io_wr_in,
    input  wire logic [ijcr_pkg::DATA_W-1:0]    sd_in,
    output logic      [ijcr_pkg::DATA_W-1:0]    sd_out,
    output logic                                sd_oe_out,
    // selections and internal reset
    output logic      [1:0]                     irq_channel_out,
    output logic      [2:0]                     io_window_out,
    output logic                                soft_reset_out,
    output logic                                soft_reset_pulse_out
);
    logic       is_isa;
    logic       sel_update;
    logic       sel_setting;
    logic       sel_reset;
    logic       cfg_loaded_q;
    logic [1:0] irq_channel_sel_q;
    logic [2:0] io_window_sel_q;
    logic       trigger;
    logic       stretched;

    function automatic logic addr_is(input logic [4:0] a,
                                     input logic [4:0] b);
        addr_is = (a == b);
    endfunction

    assign is_isa      = (mode_in == ijcr_pkg::IJCR_MODE_ISA);
    assign sel_update  = addr_is(sa_in, ijcr_pkg::IO_BASE_UPDATE_ADDR);
    assign sel_setting = addr_is(sa_in, ijcr_pkg::JUMPERLESS_SETTING_ADDR);
    assign sel_reset   = sa_in[ijcr_pkg::ADDR_W-1:
                               ijcr_pkg::SOFT_RESET_PREFIX_LSB]
                         == ijcr_pkg::SOFT_RESET_PREFIX;

    // any data, any of eight addresses, isa mode only
    assign trigger = io_wr_in && sel_reset && is_isa;

    // strap capture once after reset release when jumperless_in is set; power-on fields are zero
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
            cfg_loaded_q <= 1'b0;
        else
            cfg_loaded_q <= 1'b1;
    end

    // irq field: only power-on reset clears it, soft reset keeps it
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
            irq_channel_sel_q <= ijcr_pkg::IRQ_SEL_RESET;
        else if (!cfg_loaded_q && jumperless_in)
            irq_channel_sel_q <= irq_cfg_in;
    end

    // io field: strap load, then advance on each update read in isa mode with jumperless_in set
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
            io_window_sel_q <= ijcr_pkg::IO_SEL_RESET;
        else if (!cfg_loaded_q && jumperless_in)
            io_window_sel_q <= io_cfg_in;
        else if (io_rd_in && sel_update && is_isa && jumperless_in)
            io_window_sel_q <= io_window_sel_q + ijcr_pkg::IO_SEL_STEP;
    end

    // read data; writes to the setting register change nothing
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            sd_out    <= ijcr_pkg::READ_FILL;
            sd_oe_out <= 1'b0;
        end
        else
        begin
            sd_out    <= ijcr_pkg::READ_FILL;
            sd_oe_out <= io_rd_in && is_isa && (sel_setting || sel_update);
            if (sel_setting && jumperless_in)
            begin
                sd_out[ijcr_pkg::IRQ_SEL_MSB:ijcr_pkg::IRQ_SEL_LSB]
                    <= irq_channel_sel_q;
                sd_out[ijcr_pkg::IO_SEL_MSB:ijcr_pkg::IO_SEL_LSB]
                    <= io_window_sel_q;
            end
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            irq_channel_out <= ijcr_pkg::IRQ_SEL_RESET;
            io_window_out   <= ijcr_pkg::IO_SEL_RESET;
        end
        else
        begin
            irq_channel_out <= irq_channel_sel_q;
            io_window_out   <= io_window_sel_q;
        end
    end

    ijcr_reset_pulse #(
        .CYCLES     (ijcr_pkg::SOFT_RESET_CYCLES)
    ) u_pulse (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .trigger_in (trigger),
        .reset_out  (stretched)
    );

    // stretched reset to buffer, link, codec, transceiver, registers
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            soft_reset_out       <= 1'b0;
            soft_reset_pulse_out <= 1'b0;
        end
        else
        begin
            soft_reset_out       <= stretched;
            soft_reset_pulse_out <= trigger;
        end
    end
endmodule

// >>> include/ijcr_pkg.sv
/*
 * ijcr_pkg: constants shared by the jumperless-setting and soft-reset
 * register logic of the lan controller.
 * assumes: 8-bit isa data bus and a 5-bit system address sa[4:0].
 */
package ijcr_pkg;
    localparam int          ADDR_W = 5;
    localparam int          DATA_W = 8;

    // system address decode, sa[4:0]
    localparam logic [4:0]  IO_BASE_UPDATE_ADDR     = 5'h12;
    localparam logic [4:0]  JUMPERLESS_SETTING_ADDR = 5'h13;
    localparam logic [1:0]  SOFT_RESET_PREFIX       = 2'h3;
    localparam int          SOFT_RESET_PREFIX_LSB   = 3;

    // jumperless setting field layout
    localparam int          IRQ_SEL_MSB = 7;
    localparam int          IRQ_SEL_LSB = 6;
    localparam int          IO_SEL_MSB  = 2;
    localparam int          IO_SEL_LSB  = 0;

    localparam logic [1:0]  IRQ_SEL_RESET = 2'h0;
    localparam logic [2:0]  IO_SEL_RESET  = 3'h0;
    localparam logic [2:0]  IO_SEL_STEP   = 3'h1;
    localparam logic [7:0]  READ_FILL     = 8'h00;

    // system interface mode pins
    typedef enum logic [1:0]
    {
        IJCR_MODE_PCCARD  = 2'b00,
        IJCR_MODE_ISA     = 2'b01,
        IJCR_MODE_GENERAL = 2'b10
    } ijcr_mode_t;

    // count loaded by a soft reset write; the reset to the internal blocks lasts one cycle more
    localparam int          SOFT_RESET_CYCLES = 4;
    localparam int          SOFT_RESET_CNT_W  = 3;
endpackage

// >>> sim/ijcr_host.sv
/* isa host model issuing one-cycle read and write strobes.
   assumes: answer is registered, one cycle after the strobe. */
`timescale 1ns/1ps
module ijcr_host
(
    input  wire logic       clk_sys_in,
    input  wire logic [7:0] rdata_in,
    output logic      [4:0] sa_out,
    output logic            rd_out,
    output logic            wr_out,
    output logic      [7:0] data_out
);
    // rom upper address and rom bus width are board wiring, not driven here
    initial {sa_out, rd_out, wr_out, data_out} = '0;
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        #2 sa_out = a;
        rd_out = 1'b1;
        @(posedge clk_sys_in);
        #2 rd_out = 1'b0;
        sa_out = ~a;
        d = rdata_in;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge clk_sys_in);
        #2 sa_out = a;
        data_out = v;
        wr_out = 1'b1;
        @(posedge clk_sys_in);
        #2 wr_out = 1'b0;
        sa_out = ~a;
        data_out = ~v;
    endtask
endmodule

// >>> sim/ijcr_top_assertions.sv
/* checker on the ijcr_top ports.
   assumes: one clock domain, bound to every ijcr_top instance. */
`timescale 1ns/1ps
module ijcr_chk
(
    // clock, reset and straps
    input wire logic       clk_sys_in,
    input wire logic       rstn_in,
    input wire logic [1:0] mode_in,
    input wire logic       jumperless_in,
    // bus
    input wire logic [4:0] sa_in,
    input wire logic       io_rd_in,
    input wire logic       io_wr_in,
    input wire logic [7:0] sd_out,
    input wire logic       sd_oe_out,
    // selections and reset
    input wire logic [1:0] irq_channel_out,
    input wire logic [2:0] io_window_out,
    input wire logic       soft_reset_out,
    input wire logic       soft_reset_pulse_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    wire isa  = mode_in == ijcr_pkg::IJCR_MODE_ISA;
    wire upd  = io_rd_in && sa_in == ijcr_pkg::IO_BASE_UPDATE_ADDR;
    wire set  = io_rd_in && sa_in == ijcr_pkg::JUMPERLESS_SETTING_ADDR;
    wire sres = io_wr_in && isa && sa_in[4:3] == 2'h3;
    read_answer_a: assert property (isa && (upd || set) |=> sd_oe_out)
        else $error("read not answered");
    setting_data_a: assert property (isa && set |=> sd_out ==
        ($past(jumperless_in) ? {irq_channel_out, 3'h0, io_window_out} : 8'h00))
        else $error("setting read wrong");
    update_step_a: assert property (isa && jumperless_in && upd
        |=> ##1 io_window_out == $past(io_window_out) + 3'h1)
        else $error("io select not advanced");
    window_hold_a: assert property (!upd && $past(rstn_in)
        |=> ##1 $stable(io_window_out))
        else $error("io select moved");
    irq_keep_a: assert property (soft_reset_out |-> $stable(irq_channel_out))
        else $error("irq field lost on soft reset");
    reset_pulse_a: assert property (sres
        |=> soft_reset_pulse_out ##1 soft_reset_out [*5])
        else $error("soft reset too short");
    pulse_cause_a: assert property (!sres |=> !soft_reset_pulse_out)
        else $error("soft reset without write");
    rise_cause_a: assert property ($rose(soft_reset_out)
        |-> $past(soft_reset_pulse_out))
        else $error("soft reset without pulse");
endmodule
bind ijcr_top ijcr_chk chk (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .mode_in(mode_in), .jumperless_in(jumperless_in), .sa_in(sa_in),
    .io_rd_in(io_rd_in), .io_wr_in(io_wr_in), .sd_out(sd_out),
    .sd_oe_out(sd_oe_out), .irq_channel_out(irq_channel_out),
    .io_window_out(io_window_out), .soft_reset_out(soft_reset_out),
    .soft_reset_pulse_out(soft_reset_pulse_out));

// >>> sim/tb_ijcr_top.sv
/* self-checking bench for ijcr_top.
   assumes: host model drives the isa side, straps irq 2, io 5. */
`timescale 1ns/1ps
module tb_ijcr_top;
    logic       clk_sys_in;
    logic       rstn_in;
    logic       jumperless_in;
    logic       io_rd_in;
    logic       io_wr_in;
    logic       sd_oe_out;
    logic       srst;
    logic       spulse;
    logic [1:0] mode_in;
    logic [1:0] irq;
    logic [2:0] io;
    logic [4:0] sa_in;
    logic [7:0] sd_in;
    logic [7:0] sd_out;
    logic [7:0] d;
    int         failures = 0;
    int         comparisons = 0;
    int         i;
    ijcr_top uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .mode_in(mode_in), .jumperless_in(jumperless_in),
        .irq_cfg_in(2'h2), .io_cfg_in(3'h5), .sa_in(sa_in),
        .io_rd_in(io_rd_in), .io_wr_in(io_wr_in), .sd_in(sd_in),
        .sd_out(sd_out), .sd_oe_out(sd_oe_out), .irq_channel_out(irq),
        .io_window_out(io), .soft_reset_out(srst),
        .soft_reset_pulse_out(spulse));
    ijcr_host host (.clk_sys_in(clk_sys_in), .rdata_in(sd_out),
        .sa_out(sa_in), .rd_out(io_rd_in), .wr_out(io_wr_in),
        .data_out(sd_in));
    task automatic check(input string n, input logic [7:0] s, e);
        comparisons++;
        if (s !== e)
        begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic stop_test;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    initial
    begin
        #200000 failures++;
        stop_test;
    end
    initial
    begin
        rstn_in = 1'b0;
        mode_in = ijcr_pkg::IJCR_MODE_ISA;
        jumperless_in = 1'b1;
        repeat (12) @(posedge clk_sys_in);
        #2 check("irq at reset", {6'h0, irq}, 8'h00);
        rstn_in = 1'b1;
        host.rd(5'h13, d);
        check("setting", d, 8'h85);
        check("oe", {7'h0, sd_oe_out}, 8'h01);
        check("irq out", {6'h0, irq}, 8'h02);
        check("io out", {5'h0, io}, 8'h05);
        host.wr(5'h13, 8'hff);
        host.rd(5'h13, d);
        check("read only", d, 8'h85);
        for (i = 0; i < 3; i++)
            host.rd(5'h12, d);
        host.rd(5'h13, d);
        check("io wrap", d, 8'h80);
        check("io out wrap", {5'h0, io}, 8'h00);
        for (i = 24; i < 32; i++)
        begin
            host.wr(i[4:0], i[7:0]);
            check("pulse", {7'h0, spulse}, 8'h01);
        end
        @(posedge clk_sys_in);
        #2 check("stretch", {7'h0, srst}, 8'h01);
        host.rd(5'h13, d);
        check("kept", d, 8'h80);
        mode_in = ijcr_pkg::IJCR_MODE_PCCARD;
        host.wr(5'h1c, 8'h00);
        check("pccard", {7'h0, spulse}, 8'h00);
        mode_in = ijcr_pkg::IJCR_MODE_GENERAL;
        host.wr(5'h19, 8'h00);
        check("general", {7'h0, spulse}, 8'h00);
        mode_in = ijcr_pkg::IJCR_MODE_ISA;
        jumperless_in = 1'b0;
        host.rd(5'h13, d);
        check("jumper mode", d, 8'h00);
        host.rd(5'h12, d);
        host.rd(5'h12, d);
        check("no step", {5'h0, io}, 8'h00);
        stop_test;
    end
endmodule
